// File: usart_pkg.sv
// Constants, field layouts, types and helper functions for the serial transceiver core.
package usart_pkg;

  // Register byte offsets on the AHB-Lite bus.
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;

  // Rate factor field encodings of the mode word.
  localparam logic [1:0] RATE_SYNC = 2'h0;
  localparam logic [1:0] RATE_X1 = 2'h1;
  localparam logic [1:0] RATE_X16 = 2'h2;
  localparam logic [1:0] RATE_X64 = 2'h3;

  // Bit clock periods per bit for each factor.
  localparam logic [6:0] TICKS_X1 = 7'h01;
  localparam logic [6:0] TICKS_X16 = 7'h10;
  localparam logic [6:0] TICKS_X64 = 7'h40;

  localparam logic [3:0] CHAR_BITS_MIN = 4'h5;
  localparam logic [3:0] BUS_BITS = 4'h8;
  localparam logic [7:0] HUNT_FILL = 8'hff;

  // Reset values of the pin synchronisers: {sync pin, cts_n, rx line, tx clock, rx clock}.
  localparam logic [4:0] PIN_RST = 5'h0c;

  // Mode word. In synchronous mode stop[0] selects external sync and stop[1] one sync character.
  typedef struct packed {
    logic [1:0] stop;
    logic par_even;
    logic par_en;
    logic [1:0] len;
    logic [1:0] rate;
  } mode_t;

  typedef struct packed {
    logic hunt;
    logic irst;
    logic rts;
    logic err_rst;
    logic brk;
    logic rx_en;
    logic dtr;
    logic tx_en;
  } cmd_t;

  // Address phase of one AHB-Lite transfer, carried into its data phase.
  typedef struct packed {
    logic wr;
    logic data;
    logic ctrl;
  } bus_req_t;

  typedef enum logic [1:0] {CW_MODE, CW_SYNC1, CW_SYNC2, CW_CMD} cw_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP, RX_HUNT} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

  function automatic logic [3:0] char_bits(input logic [1:0] len);
    return CHAR_BITS_MIN + {2'h0, len};
  endfunction : char_bits

  function automatic logic [7:0] char_mask(input logic [1:0] len);
    return 8'hff >> (BUS_BITS - char_bits(len));
  endfunction : char_mask

  function automatic logic [6:0] bit_ticks(input logic [1:0] rate);
    return (rate == RATE_X16) ? TICKS_X16 : (rate == RATE_X64) ? TICKS_X64 : TICKS_X1;
  endfunction : bit_ticks

endpackage : usart_pkg

// File: usart_receive_and_setup.sv
// Serial transceiver core: AHB-Lite register slave, mode/command sequencing, transmitter, receiver.
// What this block does
// (R1) Receiver disabled forces character-available low and keeps it masked.
// (R2) Character-available rises only when enabled and a whole character reaches the holder.
// (R3) An unread held character is overwritten by the next one and overrun is flagged.
// (R4) A data read coinciding with a new transfer flags overrun; the read returns the old character.
// (R5) Sync mode: one bit per receive clock; async: receive clock divided by 1, 16 or 64.
// (R6) Sync-detect pin direction set by mode word; after reset an output driving low.
// (R7) Internal sync hunt drives sync-detect high when the sync pattern is found.
// (R8) A status read clears the sync-detect indication.
// (R9) External sync: pin rise starts assembly at next receive clock rise; internal hunt off.
// (R10) Async all-zero word raises break-detect until reset or the line returns high.
// (R11) Transmitter-ready shows a free holding register and clears on a data write.
// (R12) A data read clears character-available.
// (R13) Transmission waits for transmit enable and clear-to-send; line marks after reset.
// (R14) First control write after reset is the mode, then sync characters, then commands.
// (R15) A command with the internal reset bit resets and expects a mode word again.
// (R16) The mode is only accepted after a reset and never altered otherwise.
// (R17) Parity is not data; short characters sit low, unused bits ignored and read zero.
// (R18) Async frame: low start, data LSB first, optional parity, stop bits, on falling tx clock.
// (R19) Idle transmit line stays high, or continuously low while break is commanded.
// (R20) A falling edge starts a start bit, rechecked low at its centre in 16x/64x.
// (R21) Data and parity sampled at bit centres; parity and framing errors flagged; one stop checked.
// (R22) Error reset command clears parity, overrun and framing flags; errors never stop operation.
// (R23) Address selects control/status or data transfers.
// (R24) The system holds master reset at least six clocks with the clock running.
// (R25) In 16x/64x the start centre is found by counting 8 or 32 receive clocks.
//
// The AHB-Lite register port and the address map were left to the implementer.
`timescale 1ns/10ps
module usart_receive_and_setup (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic receive_bit_clock,
  input wire logic transmit_bit_clock,
  input wire logic rx_line,
  input wire logic clear_to_send_n,
  input wire logic sync_found_pin_i,
  output logic sync_found_pin_o,
  output logic sync_found_pin_oe,
  output logic tx_line,
  output logic rx_char_available,
  output logic tx_holding_free,
  output logic tx_all_sent,
  output logic break_found,
  output logic request_to_send_n,
  output logic terminal_ready_n
);

  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;
  logic [4:0] pin_d_reg;
  usart_pkg::bus_req_t req_reg;
  logic [31:0] hrdata_reg;
  usart_pkg::cw_state_t cw_reg;
  usart_pkg::mode_t mode_reg;
  usart_pkg::cmd_t cmd_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  usart_pkg::rx_state_t rx_state_reg;
  logic [6:0] rx_cnt_reg;
  logic [3:0] rx_bitn_reg;
  logic [7:0] rx_shift_reg;
  logic rx_par_reg;
  logic rx_or_reg;
  logic rx_prev_reg;
  logic rx_seen_high_reg;
  logic rx_en_start_reg;
  logic chk2_reg;
  logic ext_pend_reg;
  logic [7:0] rx_data_reg;
  logic rx_char_available_reg;
  logic pe_reg;
  logic oe_reg;
  logic fe_reg;
  logic sync_found_pin_reg;
  logic brk_reg;
  logic [7:0] tx_hold_reg;
  logic tx_full_reg;
  usart_pkg::tx_state_t tx_state_reg;
  logic [11:0] tx_sh_reg;
  logic [3:0] tx_left_reg;
  logic [6:0] tx_cnt_reg;
  logic tx_line_reg;

  // Synchronised pin levels and edges of the two bit clocks.
  wire rxc_s = pin_s2_reg[0];
  wire txc_s = pin_s2_reg[1];
  wire rxl = pin_s2_reg[2];
  wire cts_ok = ~pin_s2_reg[3];
  wire sin_s = pin_s2_reg[4];
  wire rx_rise = rxc_s & ~pin_d_reg[0];
  wire tx_fall = ~txc_s & pin_d_reg[1];
  wire sin_rise = sin_s & ~pin_d_reg[4];

  // Bus decode.
  wire bus_take = hsel & htrans[1] & hready & clk_en;
  wire addr_data = (haddr[7:0] == usart_pkg::ADDR_DATA); // [R23]
  wire addr_ctrl = (haddr[7:0] == usart_pkg::ADDR_CTRL); // [R23]
  wire data_rd = bus_take & ~hwrite & addr_data;
  wire stat_rd = bus_take & ~hwrite & addr_ctrl;
  wire data_wr = clk_en & req_reg.wr & req_reg.data;
  wire ctrl_wr = clk_en & req_reg.wr & req_reg.ctrl;
  wire [7:0] wbyte = hwdata[7:0];
  wire mode_wr = ctrl_wr & (cw_reg == usart_pkg::CW_MODE); // [R14] [R16]
  wire cmd_wr = ctrl_wr & (cw_reg == usart_pkg::CW_CMD);
  wire soft_rst = cmd_wr & wbyte[6]; // [R15]
  wire err_clr = cmd_wr & wbyte[4]; // [R22]
  wire hunt_cmd = cmd_wr & wbyte[7] & (mode_reg.rate == usart_pkg::RATE_SYNC);
  usart_pkg::mode_t wmode;
  assign wmode = usart_pkg::mode_t'(wbyte);

  // Format decode.
  wire is_sync = (mode_reg.rate == usart_pkg::RATE_SYNC);
  wire ext_mode = is_sync & mode_reg.stop[0];
  wire one_sync = mode_reg.stop[1];
  wire [3:0] cbits = usart_pkg::char_bits(mode_reg.len);
  wire [3:0] rx_total = cbits + {3'h0, mode_reg.par_en};
  wire [6:0] ticks = usart_pkg::bit_ticks(mode_reg.rate); // [R5]
  wire [6:0] half = ticks >> 1; // [R25]
  wire [7:0] cmask = usart_pkg::char_mask(mode_reg.len);

  // Receiver bit sampling; one sample per bit at its centre.
  wire ext_take = rx_rise & (rx_state_reg == usart_pkg::RX_HUNT) & ext_mode & ext_pend_reg; // [R9]
  wire sample_bit = (rx_rise & (rx_state_reg == usart_pkg::RX_BITS) & (rx_cnt_reg == 7'h00))
                    | ext_take; // [R21]
  wire last_bit = sample_bit & (rx_bitn_reg == rx_total - 4'h1);
  wire [7:0] shift_in = (rx_bitn_reg < cbits) ? {rxl, rx_shift_reg[7:1]} : rx_shift_reg; // [R21]
  wire [7:0] hunt_in = {rxl, rx_shift_reg[7:1]};
  wire [7:0] hunt_word = hunt_in >> (usart_pkg::BUS_BITS - cbits);
  wire hunt_match = rx_rise & (rx_state_reg == usart_pkg::RX_HUNT) & ~ext_mode
                    & (hunt_word == sync1_reg); // [R7]
  wire stop_take = rx_rise & (rx_state_reg == usart_pkg::RX_STOP) & (rx_cnt_reg == 7'h00);
  wire [7:0] rx_word = (is_sync ? shift_in : rx_shift_reg) >> (usart_pkg::BUS_BITS - cbits); // [R17]
  wire sync2_match = last_bit & chk2_reg & (rx_word == sync2_reg); // [R7]
  wire rx_deliver = stop_take | (last_bit & is_sync & ~chk2_reg);
  wire par_now = is_sync ? (rx_par_reg ^ rxl) : rx_par_reg;
  wire perr = mode_reg.par_en & (par_now ^ ~mode_reg.par_even); // [R21]
  wire en_ok = is_sync | rx_en_start_reg; // [R2]
  wire brk_hit = stop_take & ~rxl & ~rx_or_reg; // [R10]
  wire start_edge = rx_rise & (rx_state_reg == usart_pkg::RX_IDLE) & ~is_sync
                    & rx_seen_high_reg & rx_prev_reg & ~rxl; // [R20]
  wire sync_found_pin_set = hunt_match & one_sync | sync2_match | ext_take;

  // Transmitter load and frame.
  wire tx_done = (tx_state_reg == usart_pkg::TX_SEND) & (tx_cnt_reg == 7'h00)
                 & (tx_left_reg == 4'h0);
  wire tx_load = tx_fall & tx_full_reg & cmd_reg.tx_en & cts_ok
                 & ((tx_state_reg == usart_pkg::TX_IDLE) | tx_done); // [R13]
  wire [7:0] tx_md = tx_hold_reg & cmask; // [R17]
  wire tx_par = (^tx_md) ^ ~mode_reg.par_even;
  wire [11:0] tx_base = (12'hfff << cbits) | {4'h0, tx_md};
  wire [11:0] tx_frame = mode_reg.par_en ? (tx_base & ~(12'h001 << cbits))
                         | ({11'h000, tx_par} << cbits) : tx_base; // [R18]
  wire [3:0] tx_stops = mode_reg.stop[1] ? 4'h2 : 4'h1;
  wire configured = (cw_reg == usart_pkg::CW_CMD);
  wire tx_free_st = configured & ~tx_full_reg;

  wire [7:0] status = {1'h0, is_sync ? sync_found_pin_reg : brk_reg, fe_reg, oe_reg, pe_reg,
                       tx_all_sent, rx_char_available_reg, tx_free_st};

  // Outputs.
  assign hreadyout = clk_en;
  assign hresp = 1'h0;
  assign hrdata = hrdata_reg;
  assign rx_char_available = rx_char_available_reg;
  assign tx_holding_free = tx_free_st & cmd_reg.tx_en;
  assign tx_all_sent = ~tx_full_reg & (tx_state_reg == usart_pkg::TX_IDLE);
  assign tx_line = ~cmd_reg.brk & tx_line_reg; // [R19]
  assign break_found = brk_reg;
  assign sync_found_pin_o = is_sync ? sync_found_pin_reg : brk_reg;
  assign sync_found_pin_oe = ~ext_mode; // [R6]
  assign request_to_send_n = ~cmd_reg.rts;
  assign terminal_ready_n = ~cmd_reg.dtr;

  // Two-stage synchronisers, then an edge-detect stage read from the second.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_reg <= usart_pkg::PIN_RST;
      pin_s2_reg <= usart_pkg::PIN_RST;
      pin_d_reg <= usart_pkg::PIN_RST;
    end else if (clk_en) begin
      pin_s1_reg <= {sync_found_pin_i, clear_to_send_n, rx_line, transmit_bit_clock,
                     receive_bit_clock};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
    end
  end

  // Zero-wait AHB-Lite slave; read data is captured in the address phase.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_reg <= '0;
      hrdata_reg <= 32'h0000_0000;
    end else if (clk_en) begin
      req_reg <= bus_take ? {hwrite, addr_data, addr_ctrl} : 3'h0;
      hrdata_reg <= data_rd ? {24'h00_0000, rx_data_reg} :
                    stat_rd ? {24'h00_0000, status} : 32'h0000_0000;
    end
  end

  // Control write sequencer.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cw_reg <= usart_pkg::CW_MODE;
      mode_reg <= '0;
      cmd_reg <= '0;
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else if (clk_en && ctrl_wr) begin
      case (cw_reg) // [R14]
        usart_pkg::CW_MODE: begin
          mode_reg <= wmode; // [R16]
          cw_reg <= (wmode.rate == usart_pkg::RATE_SYNC) ? usart_pkg::CW_SYNC1 : usart_pkg::CW_CMD;
        end
        usart_pkg::CW_SYNC1: begin
          sync1_reg <= wbyte & cmask;
          cw_reg <= one_sync ? usart_pkg::CW_CMD : usart_pkg::CW_SYNC2;
        end
        usart_pkg::CW_SYNC2: begin
          sync2_reg <= wbyte & cmask;
          cw_reg <= usart_pkg::CW_CMD;
        end
        default: begin
          cmd_reg <= soft_rst ? '0 : usart_pkg::cmd_t'(wbyte);
          if (soft_rst) begin
            cw_reg <= usart_pkg::CW_MODE; // [R15]
          end
        end
      endcase
    end
  end

  // Receiver sequencer.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_state_reg <= usart_pkg::RX_IDLE;
      rx_cnt_reg <= 7'h00;
      rx_bitn_reg <= 4'h0;
      rx_shift_reg <= usart_pkg::HUNT_FILL;
      rx_par_reg <= 1'h0;
      rx_or_reg <= 1'h0;
      rx_prev_reg <= 1'h1;
      rx_seen_high_reg <= 1'h0;
      rx_en_start_reg <= 1'h0;
      chk2_reg <= 1'h0;
      ext_pend_reg <= 1'h0;
    end else if (clk_en) begin
      if (soft_rst || mode_wr) begin
        rx_state_reg <= (mode_wr && wmode.rate == usart_pkg::RATE_SYNC) ?
                        usart_pkg::RX_HUNT : usart_pkg::RX_IDLE;
        rx_shift_reg <= usart_pkg::HUNT_FILL;
        rx_bitn_reg <= 4'h0;
        rx_seen_high_reg <= 1'h0;
        chk2_reg <= 1'h0;
        ext_pend_reg <= 1'h0;
      end else if (hunt_cmd) begin
        rx_state_reg <= usart_pkg::RX_HUNT;
        rx_shift_reg <= usart_pkg::HUNT_FILL;
        ext_pend_reg <= 1'h0;
      end else begin
        if (sin_rise && ext_mode) begin
          ext_pend_reg <= 1'h1; // [R9]
        end
        if (rx_rise) begin
          rx_prev_reg <= rxl;
          if (rxl) begin
            rx_seen_high_reg <= 1'h1;
          end
        end
        if (start_edge) begin
          rx_bitn_reg <= 4'h0;
          rx_par_reg <= 1'h0;
          rx_or_reg <= 1'h0;
          rx_en_start_reg <= cmd_reg.rx_en;
          rx_cnt_reg <= (mode_reg.rate == usart_pkg::RATE_X1) ? 7'h00 : half - 7'h01; // [R25]
          rx_state_reg <= (mode_reg.rate == usart_pkg::RATE_X1) ?
                          usart_pkg::RX_BITS : usart_pkg::RX_START;
        end else if (rx_rise && rx_state_reg == usart_pkg::RX_START) begin
          if (rx_cnt_reg != 7'h00) begin
            rx_cnt_reg <= rx_cnt_reg - 7'h01;
          end else if (!rxl) begin
            rx_state_reg <= usart_pkg::RX_BITS; // [R20]
            rx_cnt_reg <= ticks - 7'h01;
            rx_en_start_reg <= cmd_reg.rx_en;
          end else begin
            rx_state_reg <= usart_pkg::RX_IDLE;
          end
        end else if (hunt_match) begin
          rx_state_reg <= usart_pkg::RX_BITS;
          rx_bitn_reg <= 4'h0;
          rx_par_reg <= 1'h0;
          chk2_reg <= ~one_sync;
          rx_shift_reg <= hunt_in;
        end else if (rx_rise && rx_state_reg == usart_pkg::RX_HUNT && !ext_take) begin
          rx_shift_reg <= hunt_in;
        end else if (sample_bit) begin
          rx_shift_reg <= shift_in;
          rx_par_reg <= rx_par_reg ^ rxl;
          rx_or_reg <= rx_or_reg | rxl;
          rx_cnt_reg <= ticks - 7'h01;
          rx_bitn_reg <= last_bit ? 4'h0 : rx_bitn_reg + 4'h1;
          ext_pend_reg <= 1'h0;
          if (ext_take) begin
            rx_state_reg <= usart_pkg::RX_BITS;
            rx_par_reg <= rxl;
            rx_or_reg <= rxl;
          end
          if (last_bit) begin
            chk2_reg <= 1'h0;
            if (!is_sync) begin
              rx_state_reg <= usart_pkg::RX_STOP;
            end else begin
              rx_par_reg <= 1'h0;
              if (chk2_reg && !sync2_match) begin
                rx_state_reg <= usart_pkg::RX_HUNT;
                rx_shift_reg <= usart_pkg::HUNT_FILL;
              end
            end
          end
        end else if (rx_rise && rx_state_reg != usart_pkg::RX_IDLE) begin
          if (rx_cnt_reg != 7'h00) begin
            rx_cnt_reg <= rx_cnt_reg - 7'h01;
          end else if (rx_state_reg == usart_pkg::RX_STOP) begin
            rx_state_reg <= usart_pkg::RX_IDLE; // [R21]
          end
        end
      end
    end
  end

  // Received character holder, flags and detect indications.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_data_reg <= 8'h00;
      rx_char_available_reg <= 1'h0;
      pe_reg <= 1'h0;
      oe_reg <= 1'h0;
      fe_reg <= 1'h0;
      sync_found_pin_reg <= 1'h0;
      brk_reg <= 1'h0;
    end else if (clk_en) begin
      if (soft_rst) begin
        rx_char_available_reg <= 1'h0;
        pe_reg <= 1'h0;
        oe_reg <= 1'h0;
        fe_reg <= 1'h0;
        sync_found_pin_reg <= 1'h0;
        brk_reg <= 1'h0;
      end else begin
        if (rx_deliver) begin
          rx_data_reg <= rx_word; // [R3]
        end
        if (!cmd_reg.rx_en) begin
          rx_char_available_reg <= 1'h0; // [R1]
        end else if (rx_deliver && en_ok) begin
          rx_char_available_reg <= 1'h1; // [R2]
        end else if (data_rd) begin
          rx_char_available_reg <= 1'h0; // [R12]
        end
        if (rx_deliver && (rx_char_available_reg || data_rd)) begin
          oe_reg <= 1'h1; // [R3] [R4]
        end else if (err_clr) begin
          oe_reg <= 1'h0; // [R22]
        end
        if (rx_deliver && perr) begin
          pe_reg <= 1'h1; // [R21]
        end else if (err_clr) begin
          pe_reg <= 1'h0; // [R22]
        end
        if (stop_take && !rxl) begin
          fe_reg <= 1'h1; // [R21]
        end else if (err_clr) begin
          fe_reg <= 1'h0; // [R22]
        end
        if (sync_found_pin_set) begin
          sync_found_pin_reg <= 1'h1; // [R7]
        end else if (stat_rd) begin
          sync_found_pin_reg <= 1'h0; // [R8]
        end
        if (brk_hit) begin
          brk_reg <= 1'h1; // [R10]
        end else if (rxl) begin
          brk_reg <= 1'h0; // [R10]
        end
      end
    end
  end

  // Transmitter: the holding register feeds a shifter paced by falling transmit clock edges.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_hold_reg <= 8'h00;
      tx_full_reg <= 1'h0;
      tx_state_reg <= usart_pkg::TX_IDLE;
      tx_sh_reg <= 12'hfff;
      tx_left_reg <= 4'h0;
      tx_cnt_reg <= 7'h00;
      tx_line_reg <= 1'h1; // [R13]
    end else if (clk_en) begin
      if (soft_rst) begin
        tx_full_reg <= 1'h0;
        tx_state_reg <= usart_pkg::TX_IDLE;
        tx_line_reg <= 1'h1;
      end else begin
        if (data_wr) begin
          tx_hold_reg <= wbyte;
        end
        tx_full_reg <= data_wr | (tx_full_reg & ~tx_load); // [R11]
        if (tx_load) begin
          tx_state_reg <= usart_pkg::TX_SEND;
          tx_cnt_reg <= ticks - 7'h01;
          tx_line_reg <= is_sync ? tx_frame[0] : 1'h0; // [R18]
          tx_sh_reg <= is_sync ? tx_frame >> 1 : tx_frame;
          tx_left_reg <= is_sync ? rx_total - 4'h1 : rx_total + tx_stops;
        end else if (tx_fall && tx_state_reg == usart_pkg::TX_SEND) begin
          if (tx_cnt_reg != 7'h00) begin
            tx_cnt_reg <= tx_cnt_reg - 7'h01;
          end else if (tx_left_reg == 4'h0) begin
            tx_state_reg <= usart_pkg::TX_IDLE;
            tx_line_reg <= 1'h1; // [R19]
          end else begin
            tx_line_reg <= tx_sh_reg[0]; // [R18]
            tx_sh_reg <= {1'h1, tx_sh_reg[11:1]};
            tx_left_reg <= tx_left_reg - 4'h1;
            tx_cnt_reg <= ticks - 7'h01;
          end
        end
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  rx_char_available_masked_a: assert property (clk_en && !cmd_reg.rx_en |=> !rx_char_available) // [R1]
    else $error("character-available set while the receiver is disabled");
  rx_char_available_set_a: assert property (clk_en && !soft_rst && rx_deliver && en_ok && cmd_reg.rx_en // [R2]
    |=> rx_char_available && rx_data_reg == $past(rx_word))
    else $error("delivered character did not raise character-available");
  overrun_set_a: assert property (clk_en && !soft_rst && rx_deliver && rx_char_available_reg |=> oe_reg) // [R3]
    else $error("overwritten character did not flag overrun");
  overrun_race_a: assert property (clk_en && !soft_rst && rx_deliver && data_rd |=> oe_reg) // [R4]
    else $error("read racing a transfer did not flag overrun");
  sync_found_pin_clear_a: assert property (clk_en && stat_rd && !sync_found_pin_set |=> !sync_found_pin_reg) // [R8]
    else $error("status read left sync-detect set");
  tx_holding_free_clear_a: assert property (clk_en && data_wr |=> !tx_holding_free && !tx_all_sent) // [R11]
    else $error("data write did not clear transmitter-ready");
  rx_char_available_clear_a: assert property (clk_en && data_rd && !rx_deliver |=> !rx_char_available) // [R12]
    else $error("data read did not clear character-available");
  tx_gate_a: assert property ($rose(tx_state_reg == usart_pkg::TX_SEND) // [R13]
    |-> $past(cmd_reg.tx_en) && $past(cts_ok))
    else $error("transmission began without enable and clear-to-send");
  tx_line_a: assert property ((cmd_reg.brk || tx_state_reg == usart_pkg::TX_IDLE) // [R19]
    |-> tx_line == !cmd_reg.brk)
    else $error("transmit line wrong while idle or in break");
  mode_hold_a: assert property (cw_reg != usart_pkg::CW_MODE |=> $stable(mode_reg)) // [R16]
    else $error("mode changed outside the mode phase");
  err_clear_a: assert property (clk_en && err_clr && !rx_deliver && !stop_take // [R22]
    |=> !pe_reg && !oe_reg && !fe_reg)
    else $error("error reset left an error flag set");

  char_rx_c: cover property (rx_deliver && !perr && !stop_take ##0 1'h1);
  overrun_c: cover property (rx_deliver && rx_char_available_reg);
  tx_frame_c: cover property (tx_load ##[1:1000] tx_done);
  break_c: cover property (brk_hit);

endmodule : usart_receive_and_setup

// File: serial_peer.sv
// Serial terminal model: free-running bit clock, receive frames and a transmit-line monitor.
`timescale 1ns/10ps
module serial_peer (
  output logic bit_clk,
  output logic line_out,
  input wire logic line_in,
  output logic [7:0] heard,
  output logic heard_ok
);
  initial bit_clk = 1'b0;
  always #100 bit_clk = ~bit_clk;
  // Bits change on falling edges so the core samples them mid-bit on rising edges.
  task automatic send(input logic [7:0] d, input logic stop);
    for (int i = -1; i < 9; i++) begin
      @(negedge bit_clk);
      line_out = (i < 0) ? 1'b0 : (i < 8) ? d[i] : stop;
    end
  endtask : send
  task automatic mark();
    @(negedge bit_clk);
    line_out = 1'b1;
  endtask : mark
  initial begin
    line_out = 1'b1;
    heard = 8'h00;
    heard_ok = 1'b0;
    forever begin
      @(posedge bit_clk);
      if (line_in === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          @(posedge bit_clk);
          heard[i] = line_in;
        end
        @(posedge bit_clk);
        heard_ok = line_in;
      end
    end
  end
endmodule : serial_peer

// File: usart_receive_and_setup_tb_top.sv
// Testbench: AHB-Lite tasks, frames from the peer model and checks on pins and registers.
`timescale 1ns/10ps
module usart_receive_and_setup_tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready, hresp, bclk, rxd, txd, rdy, thf, brk, sy_o, sy_oe, ok, ts;
  logic cts_n = 1'b0;
  logic [31:0] rd, q;
  logic [7:0] heard;
  int err_count = 0;
  int checks_done = 0;
  always #12.5 ref_clk = ~ref_clk;
  // The sync pin wire is pulled low whenever the core does not drive it.
  usart_receive_and_setup dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(rd), .hresp(hresp),
    .receive_bit_clock(bclk), .transmit_bit_clock(bclk), .rx_line(rxd), .clear_to_send_n(cts_n),
    .sync_found_pin_i(sy_oe ? sy_o : 1'b0), .sync_found_pin_o(sy_o), .sync_found_pin_oe(sy_oe),
    .tx_line(txd), .rx_char_available(rdy), .tx_holding_free(thf), .tx_all_sent(ts),
    .break_found(brk), .request_to_send_n(), .terminal_ready_n());
  serial_peer peer (.bit_clk(bclk), .line_out(rxd), .line_in(txd), .heard(heard), .heard_ok(ok));
  task automatic end_of_test();
    if (err_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic hold();
    logic rs;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      rs = hready;
      q = rd;
      n++;
    end while (rs !== 1'b1 && n < 20);
    if (rs !== 1'b1) begin
      err_count++;
      end_of_test();
    end
  endtask : hold
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hold();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h00_0000, d};
    hold();
    @(posedge ref_clk);
  endtask : bus
  task automatic frame(input logic [7:0] d, input logic s);
    peer.send(d, s);
    @(posedge bclk);
    repeat (8) @(posedge ref_clk);
  endtask : frame
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    chk("tx_line", 8'h01, 8'(txd));
    chk("tx_holding_free", 8'h00, 8'(thf));
    chk("sync_pin_oe", 8'h01, 8'(sy_oe));
    chk("sync_pin_o", 8'h00, 8'(sy_o));
    bus(1'b1, 8'h04, 8'h4d);
    bus(1'b1, 8'h04, 8'h01);
    chk("tx_holding_free", 8'h01, 8'(thf));
    frame(8'h3c, 1'b1);
    chk("rx_char_available", 8'h00, 8'(rdy));
    bus(1'b1, 8'h04, 8'h05);
    frame(8'h3c, 1'b1);
    chk("rx_char_available", 8'h01, 8'(rdy));
    bus(1'b0, 8'h00, 8'h00);
    chk("rx_data", 8'h3c, q[7:0]);
    chk("rx_char_available", 8'h00, 8'(rdy));
    frame(8'h11, 1'b1);
    frame(8'h22, 1'b1);
    bus(1'b0, 8'h04, 8'h00);
    chk("overrun", 8'h01, 8'(q[4]));
    bus(1'b0, 8'h00, 8'h00);
    chk("rx_data", 8'h22, q[7:0]);
    bus(1'b1, 8'h04, 8'h15);
    bus(1'b0, 8'h04, 8'h00);
    chk("overrun", 8'h00, 8'(q[4]));
    frame(8'h00, 1'b0);
    chk("break_found", 8'h01, 8'(brk));
    bus(1'b0, 8'h04, 8'h00);
    chk("framing", 8'h01, 8'(q[5]));
    cts_n <= 1'b1;
    peer.mark();
    repeat (8) @(posedge ref_clk);
    chk("break_found", 8'h00, 8'(brk));
    bus(1'b1, 8'h00, 8'ha5);
    repeat (40) @(posedge ref_clk);
    chk("tx_line_cts", 8'h01, 8'(txd));
    chk("tx_all_sent", 8'h00, 8'(ts));
    cts_n <= 1'b0;
    for (int n = 0; n < 400 && ok !== 1'b1; n++) @(posedge ref_clk);
    chk("tx_frame", 8'ha5, heard);
    chk("tx_stop", 8'h01, 8'(ok));
    repeat (8) @(posedge ref_clk);
    chk("tx_all_sent", 8'h01, 8'(ts));
    bus(1'b1, 8'h04, 8'h2d);
    chk("tx_line_break", 8'h00, 8'(txd));
    bus(1'b1, 8'h04, 8'h40);
    chk("tx_holding_free", 8'h00, 8'(thf));
    bus(1'b1, 8'h04, 8'h79);
    bus(1'b1, 8'h04, 8'h05);
    chk("tx_holding_free", 8'h01, 8'(thf));
    frame(8'h01, 1'b1);
    bus(1'b0, 8'h04, 8'h00);
    chk("parity", 8'h01, 8'(q[3]));
    chk("framing", 8'h00, 8'(q[5]));
    bus(1'b0, 8'h00, 8'h00);
    chk("rx_data", 8'h01, q[7:0]);
    end_of_test();
  end
endmodule : usart_receive_and_setup_tb_top
